// *** logic/sst_top.sv ***
// Purpose: Synchronous master transmit path with register port
// Assumes: rx_active comes from receive logic on the same clock
// Notes:   Each serial clock half lasts divider+1 clock cycles
//
// Our own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/100ps
module sst_top (
   // Clock and reset
   input  wire logic                      clk,
   input  wire logic                      rst_b,
   // Register port
   input  wire logic [sst_pkg::ADDR_W-1:0] reg_addr,
   input  wire logic [sst_pkg::DATA_W-1:0] reg_wdata,
   input  wire logic                      reg_wr,
   input  wire logic                      reg_rd,
   output logic      [sst_pkg::DATA_W-1:0] reg_rdata,
   // Half duplex with receiver
   input  wire logic                      rx_active,
   output logic                           tx_active,
   // Serial pins
   output logic                           serial_clock_line_o,
   output logic                           serial_clock_line_oe,
   output logic                           serial_data_line_o,
   output logic                           serial_data_line_oe,
   // Interrupt
   output logic                           irq
);
   sst_pkg::sst_state_e st_r;
   logic [7:0]  tx_ctrl_r;
   logic [7:0]  baud_ctrl_r;
   logic [7:0]  port_ctrl_r;
   logic [7:0]  div_lo_r;
   logic [7:0]  div_hi_r;
   logic [7:0]  irq_en_r;
   logic [7:0]  int_ctrl_r;
   logic [sst_pkg::WORD_W-1:0] buf_r;
   logic        buf_full_r;
   logic        ovr_r;
   logic [sst_pkg::WORD_W-1:0] tsr_r;
   logic [3:0]  bit_cnt_r;
   logic        phase_r;
   logic [sst_pkg::DIV_W-1:0] div_cnt_r;

   logic        wr_ctrl, wr_baud, wr_port, wr_lo, wr_hi, wr_buf, wr_clr, wr_en, wr_intc;
   logic        master, tx_ok, idle_pol, nine;
   logic [sst_pkg::DIV_W-1:0] div_val;
   logic        tick, last_bit, load_go, done, sr_empty;
   logic [1:0]  stat;
   logic        irq_any;

   assign wr_ctrl = reg_wr && reg_addr == sst_pkg::OFS_TX_CTRL;
   assign wr_baud = reg_wr && reg_addr == sst_pkg::OFS_BAUD_CTRL;
   assign wr_port = reg_wr && reg_addr == sst_pkg::OFS_PORT_CTRL;
   assign wr_lo   = reg_wr && reg_addr == sst_pkg::OFS_DIV_LO;
   assign wr_hi   = reg_wr && reg_addr == sst_pkg::OFS_DIV_HI;
   assign wr_buf  = reg_wr && reg_addr == sst_pkg::OFS_TX_BUF;
   assign wr_clr  = reg_wr && reg_addr == sst_pkg::OFS_IRQ_CLR;
   assign wr_en   = reg_wr && reg_addr == sst_pkg::OFS_IRQ_EN;
   assign wr_intc = reg_wr && reg_addr == sst_pkg::OFS_INT_CTRL;

   assign master   = tx_ctrl_r[sst_pkg::B_SYNC_SEL] && port_ctrl_r[sst_pkg::B_PORT_EN]
                     && tx_ctrl_r[sst_pkg::B_CLK_SRC];
   assign tx_ok    = master && tx_ctrl_r[sst_pkg::B_TX_EN];
   assign idle_pol = baud_ctrl_r[sst_pkg::B_IDLE_POL];
   assign nine     = tx_ctrl_r[sst_pkg::B_NINE_SEL];
   // High byte ignored unless the 16-bit divider is selected
   assign div_val  = baud_ctrl_r[sst_pkg::B_DIV16_SEL] ? {div_hi_r, div_lo_r}
                                                       : {8'h00, div_lo_r};
   assign tick     = div_cnt_r == div_val;
   assign last_bit = bit_cnt_r == 4'h0;
   assign done     = st_r == sst_pkg::SST_SHIFT && tick && phase_r && last_bit;
   // Next word only when the shifter is free and the receiver is quiet
   assign load_go  = buf_full_r && tx_ok && !rx_active
                     && (st_r == sst_pkg::SST_IDLE || done);
   assign sr_empty = st_r == sst_pkg::SST_IDLE;
   assign stat     = {ovr_r, !buf_full_r};
   assign irq_any  = |(stat & irq_en_r[1:0]) && int_ctrl_r[sst_pkg::B_GLB_IE]
                     && int_ctrl_r[sst_pkg::B_PER_IE];

   // Configuration registers
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         tx_ctrl_r   <= sst_pkg::RST_BYTE;
         baud_ctrl_r <= sst_pkg::RST_BYTE;
         port_ctrl_r <= sst_pkg::RST_BYTE;
         div_lo_r    <= sst_pkg::RST_BYTE;
         div_hi_r    <= sst_pkg::RST_BYTE;
         irq_en_r    <= sst_pkg::RST_BYTE;
         int_ctrl_r  <= sst_pkg::RST_BYTE;
      end else begin
         if (wr_ctrl) tx_ctrl_r <= reg_wdata & sst_pkg::TX_CTRL_WMASK;
         if (wr_baud) baud_ctrl_r <= reg_wdata & sst_pkg::BAUD_WMASK;
         if (wr_port) port_ctrl_r <= reg_wdata & sst_pkg::PORT_WMASK;
         if (wr_lo) div_lo_r <= reg_wdata;
         if (wr_hi) div_hi_r <= reg_wdata;
         if (wr_en) irq_en_r <= reg_wdata & sst_pkg::IRQ_WMASK;
         if (wr_intc) int_ctrl_r <= reg_wdata & sst_pkg::INTC_WMASK;
      end
   end

   // Transmit buffer; its empty flag is only cleared by a new word
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         buf_r      <= '0;
         buf_full_r <= 1'b0;
      end else if (wr_buf && !buf_full_r) begin
         // Ninth bit latched at load time, so write it first
         buf_r      <= {tx_ctrl_r[sst_pkg::B_NINTH_VAL], reg_wdata};
         buf_full_r <= 1'b1;
      end else if (wr_buf && load_go) begin
         buf_r      <= {tx_ctrl_r[sst_pkg::B_NINTH_VAL], reg_wdata};
         buf_full_r <= 1'b1;
      end else if (load_go) begin
         buf_full_r <= 1'b0;
      end
   end

   // Overrun: write to a full buffer is dropped unless a word loads that cycle; set beats clear
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ovr_r <= 1'b0;
      end else if (wr_buf && buf_full_r && !load_go) begin
         ovr_r <= 1'b1;
      end else if (wr_clr && reg_wdata[sst_pkg::B_IRQ_OVR]) begin
         ovr_r <= 1'b0;
      end
   end

   // Shifter and serial clock generation
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         st_r                <= sst_pkg::SST_IDLE;
         tsr_r               <= '0;
         bit_cnt_r           <= 4'h0;
         phase_r             <= 1'b0;
         div_cnt_r           <= sst_pkg::RST_DIV;
         serial_clock_line_o <= 1'b0;
         serial_data_line_o  <= 1'b0;
      end else if (load_go) begin
         st_r                <= sst_pkg::SST_SHIFT;
         tsr_r               <= buf_r;
         bit_cnt_r           <= nine ? 4'h8 : 4'h7;
         phase_r             <= 1'b0;
         div_cnt_r           <= sst_pkg::RST_DIV;
         serial_clock_line_o <= idle_pol;
         serial_data_line_o  <= buf_r[0];
      end else if (st_r == sst_pkg::SST_SHIFT && !tx_ok) begin
         // Dropping enable aborts the word in flight
         st_r                <= sst_pkg::SST_IDLE;
         serial_clock_line_o <= idle_pol;
      end else if (st_r == sst_pkg::SST_SHIFT) begin
         div_cnt_r <= tick ? sst_pkg::RST_DIV : div_cnt_r + 16'h0001;
         if (tick && !phase_r) begin
            phase_r             <= 1'b1;
            serial_clock_line_o <= !idle_pol;
         end else if (tick) begin
            phase_r             <= 1'b0;
            serial_clock_line_o <= idle_pol;
            if (last_bit) begin
               st_r <= sst_pkg::SST_IDLE;
            end else begin
               tsr_r              <= {1'b0, tsr_r[sst_pkg::WORD_W-1:1]};
               serial_data_line_o <= tsr_r[1];
               bit_cnt_r          <= bit_cnt_r - 4'h1;
            end
         end
      end else begin
         serial_clock_line_o <= idle_pol;
      end
   end

   // Pin enables, duplex status and interrupt line
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         serial_clock_line_oe <= 1'b0;
         serial_data_line_oe  <= 1'b0;
         tx_active            <= 1'b0;
         irq                  <= 1'b0;
      end else begin
         serial_clock_line_oe <= master;
         serial_data_line_oe  <= master;
         tx_active            <= load_go || (st_r == sst_pkg::SST_SHIFT && !done);
         irq                  <= irq_any;
      end
   end

   // Read port; the shifter itself has no address
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         reg_rdata <= sst_pkg::RST_BYTE;
      end else if (!reg_rd) begin
         reg_rdata <= sst_pkg::RST_BYTE;
      end else begin
         case (reg_addr)
            sst_pkg::OFS_TX_CTRL:   reg_rdata <= tx_ctrl_r | {6'h00, sr_empty, 1'b0};
            sst_pkg::OFS_BAUD_CTRL: reg_rdata <= baud_ctrl_r;
            sst_pkg::OFS_PORT_CTRL: reg_rdata <= port_ctrl_r;
            sst_pkg::OFS_DIV_LO:    reg_rdata <= div_lo_r;
            sst_pkg::OFS_DIV_HI:    reg_rdata <= div_hi_r;
            sst_pkg::OFS_TX_BUF:    reg_rdata <= buf_r[7:0];
            sst_pkg::OFS_IRQ_STAT:  reg_rdata <= {6'h00, stat};
            sst_pkg::OFS_IRQ_EN:    reg_rdata <= irq_en_r;
            sst_pkg::OFS_INT_CTRL:  reg_rdata <= int_ctrl_r;
            default:                reg_rdata <= sst_pkg::RST_BYTE;
         endcase
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   AST_LOAD_AFTER_LAST:
   assert property (load_go |-> (st_r == sst_pkg::SST_IDLE || done))
      else $error("shifter reloaded before last bit");

   AST_BUF_EMPTIES:
   assert property (load_go && !wr_buf |=> !buf_full_r && stat[0])
      else $error("buffer not empty after transfer");

   AST_FLAG_CLEAR_BY_LOAD:
   assert property ($fell(stat[0]) |-> $past(wr_buf))
      else $error("empty flag cleared without a buffer load");

   AST_IRQ_GATED:
   assert property (irq |-> $past(irq_any) && $past(irq_en_r[0] || irq_en_r[1]))
      else $error("interrupt without enable");

   AST_SR_EMPTY_READ:
   assert property (reg_rd && reg_addr == sst_pkg::OFS_TX_CTRL
                    |=> reg_rdata[sst_pkg::B_SR_EMPTY] == $past(sr_empty))
      else $error("shift-empty status misread");

   AST_DIV_LOW_ONLY:
   assert property (st_r == sst_pkg::SST_SHIFT && !baud_ctrl_r[sst_pkg::B_DIV16_SEL]
                    && $stable(baud_ctrl_r) |-> div_cnt_r[15:8] == 8'h00)
      else $error("high divider byte used in 8-bit mode");

   AST_MASTER_DRIVES:
   assert property (serial_clock_line_oe |-> $past(master))
      else $error("clock driven outside master mode");

   AST_TX_ENABLED:
   assert property (load_go |-> tx_ctrl_r[sst_pkg::B_TX_EN] && !rx_active)
      else $error("word started while disabled or receiving");

   AST_IDLE_LEVEL:
   assert property (sr_empty && $past(sr_empty) && $stable(idle_pol)
                    |=> serial_clock_line_o == $past(idle_pol))
      else $error("idle clock level wrong");

   AST_DONE_EMPTY:
   assert property (done && !buf_full_r |=> sr_empty ##1 sr_empty || buf_full_r)
      else $error("shift-empty not set after final bit");
endmodule // sst_top

// *** logic/sst_pkg.sv ***
// Purpose: Constants for the synchronous master serial transmitter
// Assumes: 8-bit register port, one clock domain
// Notes:   Offsets are word indices on the plain register port
package sst_pkg;
   localparam int ADDR_W = 4;
   localparam int DATA_W = 8;
   localparam int WORD_W = 9;
   localparam int DIV_W  = 16;

   // Register offsets
   localparam logic [3:0] OFS_TX_CTRL   = 4'h0;
   localparam logic [3:0] OFS_BAUD_CTRL = 4'h1;
   localparam logic [3:0] OFS_PORT_CTRL = 4'h2;
   localparam logic [3:0] OFS_DIV_LO    = 4'h3;
   localparam logic [3:0] OFS_DIV_HI    = 4'h4;
   localparam logic [3:0] OFS_TX_BUF    = 4'h5;
   localparam logic [3:0] OFS_IRQ_STAT  = 4'h6;
   localparam logic [3:0] OFS_IRQ_CLR   = 4'h7;
   localparam logic [3:0] OFS_IRQ_EN    = 4'h8;
   localparam logic [3:0] OFS_INT_CTRL  = 4'h9;

   // Field positions
   localparam int B_CLK_SRC   = 7;
   localparam int B_NINE_SEL  = 6;
   localparam int B_TX_EN     = 5;
   localparam int B_SYNC_SEL  = 4;
   localparam int B_SR_EMPTY  = 1;
   localparam int B_NINTH_VAL = 0;
   localparam int B_IDLE_POL  = 4;
   localparam int B_DIV16_SEL = 3;
   localparam int B_PORT_EN   = 7;
   localparam int B_IRQ_BUFE  = 0;
   localparam int B_IRQ_OVR   = 1;
   localparam int B_GLB_IE    = 7;
   localparam int B_PER_IE    = 6;

   // Writable masks and reset values
   localparam logic [7:0] TX_CTRL_WMASK = 8'hF1;
   localparam logic [7:0] BAUD_WMASK    = 8'h18;
   localparam logic [7:0] PORT_WMASK    = 8'h80;
   localparam logic [7:0] IRQ_WMASK     = 8'h03;
   localparam logic [7:0] INTC_WMASK    = 8'hC0;
   localparam logic [7:0] RST_BYTE      = 8'h00;
   localparam logic [15:0] RST_DIV      = 16'h0000;

   typedef enum logic [1:0] {
      SST_IDLE  = 2'b01,
      SST_SHIFT = 2'b10
   } sst_state_e;
endpackage

// *** dv/sst_slave_model.sv ***
// Purpose: Serial slave that captures words from the master clock and data pins
// Assumes: System clock is faster than the serial clock
// Notes:   A bit is taken where the clock leaves its idle level
`timescale 1ns/100ps
module sst_slave_model (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst_b,
   // Serial pins
   input  wire logic       sclk,
   input  wire logic       sclk_oe,
   input  wire logic       sdata,
   // Set-up
   input  wire logic       idle_pol,
   input  wire logic [3:0] nbits,
   // Captured words
   output logic      [8:0] word,
   output int              words
);
   logic       prev_r;
   logic [8:0] sh_r;
   int         cnt_r;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         prev_r <= 1'b0;
         sh_r   <= 9'h000;
         cnt_r  <= 0;
         word   <= 9'h000;
         words  <= 0;
      end else begin
         prev_r <= sclk;
         if (sclk_oe && prev_r === idle_pol && sclk !== idle_pol) begin
            sh_r[cnt_r] <= sdata;
            cnt_r       <= cnt_r + 1;
            if (cnt_r + 1 == int'(nbits)) begin
               word       <= sh_r;
               word[cnt_r] <= sdata;
               // Clear so a ninth bit never leaks into a later 8-bit word
               sh_r       <= 9'h000;
               cnt_r      <= 0;
               words      <= words + 1;
            end
         end
      end
   end
endmodule // sst_slave_model

// *** dv/tb_top.sv ***
// Purpose: Self-checking bench for the synchronous master transmitter
// Assumes: Divider low byte 1, so each serial half period is 2 clocks
// Notes:   Expected bit timing follows from that divider value
`timescale 1ns/100ps
module tb_top;
   logic       clk, rst_b, reg_wr, reg_rd, rx_active, tx_active, irq;
   logic       sclk, sclk_oe, sdata, sdata_oe;
   logic [3:0] reg_addr, nbits;
   logic [7:0] reg_wdata, reg_rdata, v;
   logic [8:0] word;
   int         words, fail_count, n_checks, cyc, t1;

   sst_top sst_top_i (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_active(rx_active),
      .tx_active(tx_active), .serial_clock_line_o(sclk), .serial_clock_line_oe(sclk_oe),
      .serial_data_line_o(sdata), .serial_data_line_oe(sdata_oe), .irq(irq));
   sst_slave_model sst_slave_model_i (.clk(clk), .rst_b(rst_b), .sclk(sclk),
      .sclk_oe(sclk_oe), .sdata(sdata), .idle_pol(1'b1), .nbits(nbits), .word(word),
      .words(words));

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   task wrap_up();
      $display("checks=%0d mismatches=%0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fail_count++;
         wrap_up();
      end
   end

   task chk(input logic [8:0] seen, input logic [8:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   task rd(input logic [3:0] a, input logic [7:0] exp);
      @(posedge clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
      chk({1'b0, v}, {1'b0, exp});
   endtask

   task wait_words(input int n);
      for (int i = 0; i < 2000 && words < n; i++) begin
         @(posedge clk);
         #1;
      end
      chk(9'(words), 9'(n));
   endtask

   task s_reset();
      rd(sst_pkg::OFS_TX_CTRL, 8'h02);
      rd(sst_pkg::OFS_IRQ_STAT, 8'h01);
      rd(4'hF, 8'h00);
   endtask

   task s_stream();
      wr(sst_pkg::OFS_DIV_LO, 8'h01);
      wr(sst_pkg::OFS_BAUD_CTRL, 8'h10);
      wr(sst_pkg::OFS_PORT_CTRL, 8'h80);
      wr(sst_pkg::OFS_TX_CTRL, 8'hB0);
      repeat (2) @(posedge clk);
      chk({8'h00, sclk}, 9'h001);
      chk({7'h00, sclk_oe, sdata_oe}, 9'h003);
      wr(sst_pkg::OFS_TX_BUF, 8'hA5);
      repeat (4) @(posedge clk);
      wr(sst_pkg::OFS_TX_BUF, 8'h3C);
      chk({8'h00, tx_active}, 9'h001);
      rd(sst_pkg::OFS_TX_CTRL, 8'hB0);
      rd(sst_pkg::OFS_IRQ_STAT, 8'h00);
      wait_words(1);
      t1 = cyc;
      chk(word, 9'h0A5);
      wait_words(2);
      chk(9'(cyc - t1), 9'h020);
      chk(word, 9'h03C);
      repeat (6) @(posedge clk);
      rd(sst_pkg::OFS_TX_CTRL, 8'hB2);
      rd(sst_pkg::OFS_IRQ_STAT, 8'h01);
      chk({8'h00, sclk}, 9'h001);
   endtask

   task s_nine();
      nbits <= 4'h9;
      wr(sst_pkg::OFS_TX_CTRL, 8'hF1);
      wr(sst_pkg::OFS_TX_BUF, 8'h55);
      wait_words(3);
      chk(word, 9'h155);
      nbits <= 4'h8;
   endtask

   task s_irq();
      wr(sst_pkg::OFS_IRQ_EN, 8'h01);
      repeat (3) @(posedge clk);
      chk({8'h00, irq}, 9'h000);
      wr(sst_pkg::OFS_INT_CTRL, 8'hC0);
      repeat (3) @(posedge clk);
      chk({8'h00, irq}, 9'h001);
      wr(sst_pkg::OFS_IRQ_STAT, 8'h00);
      wr(sst_pkg::OFS_IRQ_CLR, 8'h01);
      rd(sst_pkg::OFS_IRQ_STAT, 8'h01);
      wr(sst_pkg::OFS_IRQ_EN, 8'h00);
      repeat (3) @(posedge clk);
      chk({8'h00, irq}, 9'h000);
      rd(sst_pkg::OFS_IRQ_STAT, 8'h01);
   endtask

   task s_block();
      wr(sst_pkg::OFS_TX_CTRL, 8'hB0);
      rx_active <= 1'b1;
      wr(sst_pkg::OFS_TX_BUF, 8'h11);
      repeat (20) @(posedge clk);
      chk(9'(words), 9'h003);
      wr(sst_pkg::OFS_TX_CTRL, 8'h90);
      rx_active <= 1'b0;
      repeat (20) @(posedge clk);
      chk(9'(words), 9'h003);
      chk({8'h00, sclk}, 9'h001);
      wr(sst_pkg::OFS_TX_CTRL, 8'hB0);
      wait_words(4);
      chk(word, 9'h011);
   endtask

   initial begin
      rst_b     = 1'b0;
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
      reg_addr  = 4'h0;
      reg_wdata = 8'h00;
      rx_active = 1'b0;
      nbits     = 4'h8;
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      s_reset();
      s_stream();
      s_nine();
      s_irq();
      s_block();
      wrap_up();
   end
endmodule // tb_top
